// file: design/smlc_pkg.sv
// package: register map, field positions, reset values and timing counts
package smlc_pkg;
	// register byte addresses
	localparam logic [7:0] ADDR_LOW_BATTERY_CONFIG = 8'h00;
	localparam logic [7:0] ADDR_CLOCK_DIV          = 8'h04;
	localparam logic [7:0] ADDR_LOCK_CTRL          = 8'h08;
	localparam logic [7:0] ADDR_LOCK_STATUS        = 8'h0c;
	localparam logic [7:0] ADDR_VCO_TUNE           = 8'h10;
	localparam logic [7:0] ADDR_TX_CTRL            = 8'h14;
	localparam logic [7:0] ADDR_RESET_STATUS       = 8'h18;
	localparam logic [7:0] ADDR_IRQ_STATUS         = 8'h1c;
	localparam logic [7:0] ADDR_IRQ_ENABLE         = 8'h20;
	localparam logic [7:0] ADDR_IRQ_CLEAR          = 8'h24;
	// low_battery_config fields
	localparam int LB_WARN_BIT  = 7;
	localparam int LB_VALID_BIT = 6;
	localparam logic [5:0] LB_THRESH_RESET = 6'h00;
	// clock divider: core clock = master / (ratio + 1)
	localparam logic [7:0] CLK_DIV_RESET = 8'h0f;
	// lock detector defaults (window length in clock cycles, delays in observation windows, limit in slips)
	localparam logic [7:0] LOCK_WINDOW_RESET = 8'h3f;
	localparam logic [3:0] SLIP_LIMIT_RESET  = 4'h2;
	localparam logic [3:0] LOCK_DLY_RESET    = 4'h4;
	localparam logic [3:0] UNLOCK_DLY_RESET  = 4'h2;
	// vco tuning and attenuation
	localparam logic [4:0] VCO_CAP_RESET = 5'h10;
	localparam logic [5:0] ATTEN_MAX     = 6'h24;
	// low-battery result settles this long after a threshold write
	localparam int LB_SETTLE_NS     = 1000;
	localparam int CLK_PERIOD_NS    = 50;
	localparam int LB_SETTLE_CYCLES = (LB_SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	// interrupt bits
	localparam int IRQ_BROWNOUT = 0;
	localparam int IRQ_LOWBAT   = 1;
	localparam int IRQ_LOCK     = 2;
	localparam int IRQ_UNLOCK   = 3;
	localparam int IRQ_W        = 4;
endpackage

// file: design/smlc_lock_if.sv
// interface between the top and the lock detector
`timescale 1ns/1ps
interface smlc_lock_if;
	logic [7:0] window_len;
	logic [3:0] slip_limit;
	logic [3:0] lock_dly;
	logic [3:0] unlock_dly;
	logic       locked;
	logic [3:0] last_slips;
	modport ctrl (output window_len, output slip_limit, output lock_dly, output unlock_dly,
		input locked, input last_slips);
	modport det (input window_len, input slip_limit, input lock_dly, input unlock_dly,
		output locked, output last_slips);
endinterface

// file: design/smlc_lock_det.sv
// pll lock detector: counts cycle slips per window, delayed lock/unlock
`timescale 1ns/1ps
module smlc_lock_det (
	// clock and reset
	input  wire logic   clk,
	input  wire logic   rst_n,
	// slip pulse from the phase detector
	input  wire logic   slip,
	// settings and result
	smlc_lock_if.det    lk
);
	typedef struct packed {
		logic [7:0] win_cnt;
		logic [3:0] slips;
		logic [3:0] good_cnt;
		logic [3:0] bad_cnt;
		logic       locked;
		logic [3:0] last_slips;
	} smlc_ld_s;

	smlc_ld_s st;
	smlc_ld_s next_st;

	// window close decides good or bad; runs of windows act as the delays
	always_comb begin
		next_st = st;
		if (slip && st.slips != 4'hf) begin
			next_st.slips = st.slips + 4'h1;
		end
		if (st.win_cnt >= lk.window_len) begin
			next_st.win_cnt = 8'h00;
			next_st.slips = 4'h0;
			next_st.last_slips = st.slips;
			if (st.slips <= lk.slip_limit) begin
				next_st.bad_cnt = 4'h0;
				if (st.good_cnt >= lk.lock_dly) begin
					next_st.locked = 1'b1;
				end else begin
					next_st.good_cnt = st.good_cnt + 4'h1;
				end
			end else begin
				next_st.good_cnt = 4'h0;
				if (st.bad_cnt >= lk.unlock_dly) begin
					next_st.locked = 1'b0;
				end else begin
					next_st.bad_cnt = st.bad_cnt + 4'h1;
				end
			end
		end else begin
			next_st.win_cnt = st.win_cnt + 8'h01;
		end
	end

	// state register
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end

	assign lk.locked     = st.locked;
	assign lk.last_slips = st.last_slips;
endmodule

// file: design/smlc_top.sv
// supply monitor, reset sequencing, lock control, clock divider and tx gating
//
// Operation
// - brown-out forces and holds the whole chip in reset
// - slight supply recovery above brown-out leaves reset by warm reboot
// - supply collapse then power-on rise gives a cold start
// - low-battery comparator trip sets warning bit 7
// - bit 6 shows the warning bit holds a valid result
// - bits 5..0 are the writable low-battery threshold code
// - any threshold code is accepted, even below brown-out
// - lock decided by counting cycle slips per observation window
// - programmable lock delay, unlock delay and slip limit
// - core clock from master clock through programmable divider
// - five-bit selector picks one of thirty-two vco capacitor steps
// - window comparator tuning result is readable by software
// - transmit data bit gates the carrier on and off
// - attenuation 0..36 db in 1 db steps through a control field
`timescale 1ns/1ps
module smlc_top (
	// clock and reset
	input  wire logic        CORE_CLK,
	input  wire logic        RST_B,
	// axi4-lite write address
	input  wire logic        S_AXI_AWVALID,
	output logic             S_AXI_AWREADY,
	input  wire logic [7:0]  S_AXI_AWADDR,
	// axi4-lite write data
	input  wire logic        S_AXI_WVALID,
	output logic             S_AXI_WREADY,
	input  wire logic [31:0] S_AXI_WDATA,
	input  wire logic [3:0]  S_AXI_WSTRB,
	// axi4-lite write response
	output logic             S_AXI_BVALID,
	input  wire logic        S_AXI_BREADY,
	output logic [1:0]       S_AXI_BRESP,
	// axi4-lite read
	input  wire logic        S_AXI_ARVALID,
	output logic             S_AXI_ARREADY,
	input  wire logic [7:0]  S_AXI_ARADDR,
	output logic             S_AXI_RVALID,
	input  wire logic        S_AXI_RREADY,
	output logic [31:0]      S_AXI_RDATA,
	output logic [1:0]       S_AXI_RRESP,
	// analog comparators (asynchronous)
	input  wire logic        BROWNOUT,
	input  wire logic        SUPPLY_NEAR_ZERO,
	input  wire logic        LOW_BATTERY,
	input  wire logic        VCO_WINDOW_HIGH,
	input  wire logic        VCO_WINDOW_LOW,
	input  wire logic        CYCLE_SLIP,
	// transmit data and analog controls
	input  wire logic        TX_DATA,
	output logic             CHIP_RESET_B,
	output logic             CORE_CLK_EN,
	output logic [5:0]       LB_THRESHOLD,
	output logic [4:0]       VCO_CAP_SEL,
	output logic             PA_ENABLE,
	output logic [5:0]       PA_ATTEN,
	output logic             IRQ
);
	localparam int IRQ_W_T = smlc_pkg::IRQ_W;

	typedef enum logic [2:0] {
		SEQ_COLD = 3'b001,
		SEQ_RUN  = 3'b010,
		SEQ_HOLD = 3'b100
	} smlc_seq_e;

	typedef struct packed {
		logic [1:0]  bo_sync;
		logic [1:0]  zero_sync;
		logic [1:0]  lb_sync;
		logic [1:0]  whi_sync;
		logic [1:0]  wlo_sync;
		smlc_seq_e   seq;
		logic        warm_boot;
		logic        collapsed;
		logic [5:0]  lb_thresh;
		logic        lb_warn;
		logic        lb_valid;
		logic [7:0]  settle;
		logic [7:0]  div_ratio;
		logic [7:0]  div_cnt;
		logic [7:0]  win_len;
		logic [3:0]  slip_lim;
		logic [3:0]  lock_dly;
		logic [3:0]  unlock_dly;
		logic        lock_q;
		logic [4:0]  vco_cap;
		logic        tx_en;
		logic [5:0]  atten;
		logic [IRQ_W_T-1:0] irq_stat;
		logic [IRQ_W_T-1:0] irq_en;
		logic        aw_full;
		logic [7:0]  aw_addr;
		logic        w_full;
		logic [31:0] w_data;
		logic [3:0]  w_strb;
		logic        bvalid;
		logic        rvalid;
		logic [31:0] rdata;
	} smlc_state_s;

	logic [1:0]  rst_sync;
	logic        rst_n;
	smlc_state_s st;
	smlc_state_s next_st;
	logic        lb_write;
	logic [31:0] rd_word;

	smlc_lock_if lk ();

	// reset release through two flops
	always_ff @(posedge CORE_CLK or negedge RST_B) begin
		if (!RST_B) begin
			rst_sync <= 2'b00;
		end else begin
			rst_sync <= {rst_sync[0], 1'b1};
		end
	end
	assign rst_n = rst_sync[1];

	assign lk.window_len = st.win_len;
	assign lk.slip_limit = st.slip_lim;
	assign lk.lock_dly   = st.lock_dly;
	assign lk.unlock_dly = st.unlock_dly;

	smlc_lock_det u_lock (
		.clk   (CORE_CLK),
		.rst_n (rst_n),
		.slip  (CYCLE_SLIP),
		.lk    (lk.det)
	);

	// read mux, unmapped addresses read zero
	always_comb begin
		rd_word = 32'h0000_0000;
		if (S_AXI_ARADDR == smlc_pkg::ADDR_LOW_BATTERY_CONFIG) begin
			rd_word = {24'h0, st.lb_warn, st.lb_valid, st.lb_thresh};
		end else if (S_AXI_ARADDR == smlc_pkg::ADDR_CLOCK_DIV) begin
			rd_word = {24'h0, st.div_ratio};
		end else if (S_AXI_ARADDR == smlc_pkg::ADDR_LOCK_CTRL) begin
			rd_word = {8'h0, st.lock_dly, st.unlock_dly, 4'h0, st.slip_lim, st.win_len};
		end else if (S_AXI_ARADDR == smlc_pkg::ADDR_LOCK_STATUS) begin
			rd_word = {27'h0, lk.last_slips, lk.locked};
		end else if (S_AXI_ARADDR == smlc_pkg::ADDR_VCO_TUNE) begin
			rd_word = {22'h0, st.wlo_sync[1], st.whi_sync[1], 3'h0, st.vco_cap};
		end else if (S_AXI_ARADDR == smlc_pkg::ADDR_TX_CTRL) begin
			rd_word = {23'h0, st.tx_en, 2'h0, st.atten};
		end else if (S_AXI_ARADDR == smlc_pkg::ADDR_RESET_STATUS) begin
			rd_word = {29'h0, st.warm_boot, st.bo_sync[1], st.collapsed};
		end else if (S_AXI_ARADDR == smlc_pkg::ADDR_IRQ_STATUS) begin
			rd_word = {28'h0, st.irq_stat};
		end else if (S_AXI_ARADDR == smlc_pkg::ADDR_IRQ_ENABLE) begin
			rd_word = {28'h0, st.irq_en};
		end
	end

	assign lb_write = st.aw_full && st.w_full && !st.bvalid
		&& st.aw_addr == smlc_pkg::ADDR_LOW_BATTERY_CONFIG && st.w_strb[0];

	// next-state: sync, sequencer, divider, registers, bus
	always_comb begin
		logic [IRQ_W_T-1:0] ev;
		logic [IRQ_W_T-1:0] clr;
		ev  = '0;
		clr = '0;
		next_st = st;
		// comparator inputs except CYCLE_SLIP pass two flops before anything looks at them
		next_st.bo_sync   = {st.bo_sync[0], BROWNOUT};
		next_st.zero_sync = {st.zero_sync[0], SUPPLY_NEAR_ZERO};
		next_st.lb_sync   = {st.lb_sync[0], LOW_BATTERY};
		next_st.whi_sync  = {st.whi_sync[0], VCO_WINDOW_HIGH};
		next_st.wlo_sync  = {st.wlo_sync[0], VCO_WINDOW_LOW};
		// reset sequencer
		case (st.seq)
			SEQ_COLD: begin
				if (!st.bo_sync[1]) begin
					next_st.seq = SEQ_RUN;
				end
			end
			SEQ_RUN: begin
				if (st.bo_sync[1]) begin
					next_st.seq = SEQ_HOLD;
					ev[smlc_pkg::IRQ_BROWNOUT] = 1'b1;
				end
			end
			SEQ_HOLD: begin
				if (st.zero_sync[1]) begin
					next_st.collapsed = 1'b1;
				end
				if (!st.bo_sync[1]) begin
					if (st.collapsed || st.zero_sync[1]) begin
						next_st.seq = SEQ_COLD;
					end else begin
						next_st.seq = SEQ_RUN;
						next_st.warm_boot = 1'b1;
					end
				end
			end
			default: begin
				next_st.seq = SEQ_COLD;
			end
		endcase
		// cold start: registers other than lock control, irq status and the low-battery warning and valid bits return to power-on values, as first insertion
		if (st.seq == SEQ_HOLD && !st.bo_sync[1] && (st.collapsed || st.zero_sync[1])) begin
			next_st.lb_thresh = smlc_pkg::LB_THRESH_RESET;
			next_st.div_ratio = smlc_pkg::CLK_DIV_RESET;
			next_st.vco_cap   = smlc_pkg::VCO_CAP_RESET;
			next_st.tx_en     = 1'b0;
			next_st.atten     = 6'h00;
			next_st.irq_en    = '0;
			next_st.warm_boot = 1'b0;
			next_st.collapsed = 1'b0;
		end
		// core clock enable divider
		if (st.div_cnt >= st.div_ratio) begin
			next_st.div_cnt = 8'h00;
		end else begin
			next_st.div_cnt = st.div_cnt + 8'h01;
		end
		// low battery: result invalid while the comparator settles after a threshold write
		if (st.settle != 8'h00) begin
			next_st.settle = st.settle - 8'h01;
		end else begin
			next_st.lb_valid = 1'b1;
			next_st.lb_warn  = st.lb_sync[1];
			if (st.lb_sync[1] && !st.lb_warn) begin
				ev[smlc_pkg::IRQ_LOWBAT] = 1'b1;
			end
		end
		// lock edges
		next_st.lock_q = lk.locked;
		ev[smlc_pkg::IRQ_LOCK]   = lk.locked && !st.lock_q;
		ev[smlc_pkg::IRQ_UNLOCK] = !lk.locked && st.lock_q;
		// write address and data taken in either order
		if (S_AXI_AWVALID && !st.aw_full) begin
			next_st.aw_full = 1'b1;
			next_st.aw_addr = S_AXI_AWADDR;
		end
		if (S_AXI_WVALID && !st.w_full) begin
			next_st.w_full = 1'b1;
			next_st.w_data = S_AXI_WDATA;
			next_st.w_strb = S_AXI_WSTRB;
		end
		if (st.aw_full && st.w_full && !st.bvalid) begin
			next_st.bvalid = 1'b1;
			next_st.aw_full = 1'b0;
			next_st.w_full = 1'b0;
			if (st.w_strb[0]) begin
				if (lb_write) begin
					next_st.lb_thresh = st.w_data[5:0];
					next_st.lb_valid  = 1'b0;
					next_st.settle    = 8'(smlc_pkg::LB_SETTLE_CYCLES);
				end else if (st.aw_addr == smlc_pkg::ADDR_CLOCK_DIV) begin
					next_st.div_ratio = st.w_data[7:0];
				end else if (st.aw_addr == smlc_pkg::ADDR_LOCK_CTRL) begin
					next_st.win_len = st.w_data[7:0];
				end else if (st.aw_addr == smlc_pkg::ADDR_VCO_TUNE) begin
					next_st.vco_cap = st.w_data[4:0];
				end else if (st.aw_addr == smlc_pkg::ADDR_TX_CTRL) begin
					// out-of-range codes clamp to full attenuation
					next_st.atten = (st.w_data[5:0] > smlc_pkg::ATTEN_MAX) ? smlc_pkg::ATTEN_MAX
						: st.w_data[5:0];
				end else if (st.aw_addr == smlc_pkg::ADDR_IRQ_ENABLE) begin
					next_st.irq_en = st.w_data[IRQ_W_T-1:0];
				end else if (st.aw_addr == smlc_pkg::ADDR_IRQ_CLEAR) begin
					clr = st.w_data[IRQ_W_T-1:0];
				end else if (st.aw_addr == smlc_pkg::ADDR_RESET_STATUS) begin
					// clears ignored while held, so a warm-boot set in that cycle is never lost
					next_st.warm_boot = next_st.warm_boot & ~(st.w_data[2] & (st.seq != SEQ_HOLD));
				end
			end
			if (st.w_strb[1]) begin
				if (st.aw_addr == smlc_pkg::ADDR_LOCK_CTRL) begin
					next_st.slip_lim = st.w_data[11:8];
				end else if (st.aw_addr == smlc_pkg::ADDR_TX_CTRL) begin
					next_st.tx_en = st.w_data[8];
				end
			end
			if (st.w_strb[2] && st.aw_addr == smlc_pkg::ADDR_LOCK_CTRL) begin
				next_st.unlock_dly = st.w_data[19:16];
				next_st.lock_dly   = st.w_data[23:20];
			end
		end
		if (st.bvalid && S_AXI_BREADY) begin
			next_st.bvalid = 1'b0;
		end
		// read: one cycle from address to data
		if (S_AXI_ARVALID && !st.rvalid) begin
			next_st.rvalid = 1'b1;
			next_st.rdata  = rd_word;
		end else if (st.rvalid && S_AXI_RREADY) begin
			next_st.rvalid = 1'b0;
		end
		// sticky status: a set in the clear cycle wins
		next_st.irq_stat = (st.irq_stat & ~clr) | ev;
	end

	// state register
	always_ff @(posedge CORE_CLK or negedge rst_n) begin
		if (!rst_n) begin
			st            <= '0;
			st.seq        <= SEQ_COLD;
			st.lb_thresh  <= smlc_pkg::LB_THRESH_RESET;
			st.settle     <= 8'(smlc_pkg::LB_SETTLE_CYCLES);
			st.div_ratio  <= smlc_pkg::CLK_DIV_RESET;
			st.win_len    <= smlc_pkg::LOCK_WINDOW_RESET;
			st.slip_lim   <= smlc_pkg::SLIP_LIMIT_RESET;
			st.lock_dly   <= smlc_pkg::LOCK_DLY_RESET;
			st.unlock_dly <= smlc_pkg::UNLOCK_DLY_RESET;
			st.vco_cap    <= smlc_pkg::VCO_CAP_RESET;
		end else begin
			st <= next_st;
		end
	end

	// outputs
	assign S_AXI_AWREADY = !st.aw_full;
	assign S_AXI_WREADY  = !st.w_full;
	assign S_AXI_BVALID  = st.bvalid;
	assign S_AXI_BRESP   = 2'b00;
	assign S_AXI_ARREADY = !st.rvalid;
	assign S_AXI_RVALID  = st.rvalid;
	assign S_AXI_RDATA   = st.rdata;
	assign S_AXI_RRESP   = 2'b00;
	assign CHIP_RESET_B  = st.seq == SEQ_RUN;
	assign CORE_CLK_EN   = st.div_cnt == 8'h00;
	assign LB_THRESHOLD  = st.lb_thresh;
	assign VCO_CAP_SEL   = st.vco_cap;
	// carrier only passes while transmitting, out of reset, and keyed by data
	assign PA_ENABLE     = st.tx_en && TX_DATA && st.seq == SEQ_RUN;
	assign PA_ATTEN      = st.atten;
	assign IRQ           = |(st.irq_stat & st.irq_en);
endmodule

// file: bench/smlc_afe_model.sv
// analog front end model: supply and tuning comparators, slip pulses
`timescale 1ns/1ps
module smlc_afe_model #(
	parameter logic [11:0] BO_MV = 12'h708,
	parameter logic [11:0] NZ_MV = 12'h064
) (
	// clock
	input  wire logic        clk,
	// supply, warning level and tuning state in millivolts
	input  wire logic [11:0] sup,
	input  wire logic [11:0] lbmv,
	input  wire logic [1:0]  win,
	input  wire logic        slip_en,
	// comparator outputs
	output logic             bo,
	output logic             nz,
	output logic             lb,
	output logic             wh,
	output logic             wl,
	output logic             sl
);
	// plain level compares, no hysteresis modelled
	assign bo = sup < BO_MV;
	assign nz = sup < NZ_MV;
	assign lb = sup < lbmv;
	assign wh = win[1];
	assign wl = win[0];
	// a slip every other cycle, enough to break the 8-cycle window, limit 2 lock the test uses
	always_ff @(posedge clk) begin
		sl <= slip_en && !sl;
	end
endmodule

// file: bench/smlc_top_sva.sv
// checker: concurrent assertions on the top module ports
`timescale 1ns/1ps
module smlc_top_sva (
	// clock and reset
	input wire logic        CORE_CLK,
	input wire logic        RST_B,
	// bus answers
	input wire logic        S_AXI_BVALID,
	input wire logic        S_AXI_BREADY,
	input wire logic [1:0]  S_AXI_BRESP,
	input wire logic        S_AXI_RVALID,
	input wire logic        S_AXI_RREADY,
	input wire logic [31:0] S_AXI_RDATA,
	input wire logic        S_AXI_ARREADY,
	// supply, clock and transmit
	input wire logic        BROWNOUT,
	input wire logic        TX_DATA,
	input wire logic        CHIP_RESET_B,
	input wire logic        CORE_CLK_EN,
	input wire logic        PA_ENABLE,
	input wire logic [5:0]  PA_ATTEN
);
	default clocking @(posedge CORE_CLK); endclocking
	default disable iff (!RST_B);
	// four samples cover the two sync flops and the state register
	hold_reset_a: assert property (BROWNOUT [*4] |=> !CHIP_RESET_B)
		else $error("chip reset not held in brownout");
	release_run_a: assert property ($fell(BROWNOUT) ##1 !BROWNOUT [*5] |-> CHIP_RESET_B)
		else $error("chip reset not released after recovery");
	ook_gate_a: assert property (PA_ENABLE |-> TX_DATA && CHIP_RESET_B)
		else $error("carrier on without data bit");
	atten_range_a: assert property (PA_ATTEN <= 6'h24)
		else $error("attenuation beyond range");
	// divider keeps counting while the chip is held; a held chip also ends the wait
	div_pulse_a: assert property (CORE_CLK_EN |=> ##[0:255] (CORE_CLK_EN || !CHIP_RESET_B))
		else $error("core clock enable missing");
	b_hold_a: assert property (S_AXI_BVALID && !S_AXI_BREADY |=> S_AXI_BVALID)
		else $error("write response dropped early");
	r_hold_a: assert property (S_AXI_RVALID && !S_AXI_RREADY |=> S_AXI_RVALID && $stable(S_AXI_RDATA))
		else $error("read data not held");
	resp_ok_a: assert property (S_AXI_BVALID |-> S_AXI_BRESP == 2'h0)
		else $error("write refused");
	ar_block_a: assert property (S_AXI_RVALID |-> !S_AXI_ARREADY)
		else $error("read taken while answer pending");
	cover property (BROWNOUT ##1 !CHIP_RESET_B);
	cover property (PA_ENABLE);
	cover property (S_AXI_RVALID && S_AXI_RREADY);
endmodule
bind smlc_top smlc_top_sva chk_u (.CORE_CLK, .RST_B, .S_AXI_BVALID, .S_AXI_BREADY, .S_AXI_BRESP,
	.S_AXI_RVALID, .S_AXI_RREADY, .S_AXI_RDATA, .S_AXI_ARREADY, .BROWNOUT, .TX_DATA,
	.CHIP_RESET_B, .CORE_CLK_EN, .PA_ENABLE, .PA_ATTEN);

// file: bench/tb_top.sv
// testbench: register sequences against supply, lock, divider and transmit logic
`timescale 1ns/1ps
module tb_top;
	logic        clk, rst_b, awv, wv, brdy, arv, rrdy, tx, slip_en;
	logic [7:0]  awa, ara;
	logic [31:0] wd, rd;
	logic [11:0] sup, lbmv;
	logic [1:0]  win;
	wire logic   awr, wr_, bv, arr, rv, bo, nz, lb, wh, wl, sl, crb, cke, pae, irq;
	wire logic [1:0]  br, rr;
	wire logic [31:0] rdata;
	wire logic [5:0]  lbt, att;
	wire logic [4:0]  cap;
	int          miscompares, compares, cyc, n;
	smlc_top dut_u (.CORE_CLK(clk), .RST_B(rst_b), .S_AXI_AWVALID(awv), .S_AXI_AWREADY(awr),
		.S_AXI_AWADDR(awa), .S_AXI_WVALID(wv), .S_AXI_WREADY(wr_), .S_AXI_WDATA(wd),
		.S_AXI_WSTRB(4'hf), .S_AXI_BVALID(bv), .S_AXI_BREADY(brdy), .S_AXI_BRESP(br),
		.S_AXI_ARVALID(arv), .S_AXI_ARREADY(arr), .S_AXI_ARADDR(ara), .S_AXI_RVALID(rv),
		.S_AXI_RREADY(rrdy), .S_AXI_RDATA(rdata), .S_AXI_RRESP(rr), .BROWNOUT(bo),
		.SUPPLY_NEAR_ZERO(nz), .LOW_BATTERY(lb), .VCO_WINDOW_HIGH(wh), .VCO_WINDOW_LOW(wl),
		.CYCLE_SLIP(sl), .TX_DATA(tx), .CHIP_RESET_B(crb), .CORE_CLK_EN(cke),
		.LB_THRESHOLD(lbt), .VCO_CAP_SEL(cap), .PA_ENABLE(pae), .PA_ATTEN(att), .IRQ(irq));
	smlc_afe_model afe_u (.clk(clk), .sup(sup), .lbmv(lbmv), .win(win), .slip_en(slip_en),
		.bo(bo), .nz(nz), .lb(lb), .wh(wh), .wl(wl), .sl(sl));
	// clock
	initial begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end
	task automatic report_and_stop;
		$display("compares %0d miscompares %0d", compares, miscompares);
		if (miscompares == 0 && compares > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	// hang guard, the whole run needs about 650 cycles
	always @(posedge clk) begin
		cyc++;
		if (cyc == 20000) begin
			miscompares++;
			report_and_stop;
		end
	end
	task automatic chk(input logic [31:0] s, input logic [31:0] e);
		compares++;
		if (s !== e) begin
			miscompares++;
			$display("mismatch at %0t seen %h expected %h", $time, s, e);
		end
	endtask
	// ready and valid are sampled mid-cycle, where they have settled
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic ta, tw, tb;
		@(posedge clk);
		awv <= 1'b1;
		wv <= 1'b1;
		awa <= a;
		wd <= d;
		brdy <= 1'b1;
		do begin
			@(negedge clk);
			ta = awv && awr;
			tw = wv && wr_;
			tb = bv;
			@(posedge clk);
			if (ta) awv <= 1'b0;
			if (tw) wv <= 1'b0;
		end while (!tb);
		brdy <= 1'b0;
	endtask
	task automatic rc(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
		logic ta, t;
		logic [1:0] rs;
		@(posedge clk);
		arv <= 1'b1;
		ara <= a;
		rrdy <= 1'b1;
		do begin
			@(negedge clk);
			ta = arv && arr;
			t = rv;
			rd = rdata;
			rs = rr;
			@(posedge clk);
			if (ta) arv <= 1'b0;
		end while (!t);
		rrdy <= 1'b0;
		chk(rd & m, e);
		chk(rs, 0);
	endtask
	// ends mid-cycle so ports are looked at once settled
	task automatic cy(input int k);
		repeat (k) @(posedge clk);
		@(negedge clk);
	endtask
	task automatic endt(input string s);
		$display("test %s done", s);
	endtask
	initial begin
		{rst_b, awv, wv, brdy, arv, rrdy, tx, slip_en, awa, ara, wd, win} = '0;
		sup = 12'hce4;
		lbmv = 12'h960;
		miscompares = 0;
		compares = 0;
		cyc = 0;
		repeat (8) @(posedge clk);
		rst_b <= 1'b1;
		cy(6);
		chk(crb, 1);
		rc(smlc_pkg::ADDR_CLOCK_DIV, 'hff, 'h0f);
		rc(smlc_pkg::ADDR_VCO_TUNE, 'h1f, 'h10);
		rc(8'h3c, '1, 0);
		endt("defaults");
		wr(smlc_pkg::ADDR_CLOCK_DIV, 3);
		do @(negedge clk); while (cke !== 1'b1);
		n = 0;
		do begin
			@(negedge clk);
			n++;
		end while (cke !== 1'b1);
		chk(n, 4);
		endt("divider");
		wr(smlc_pkg::ADDR_LOW_BATTERY_CONFIG, 'h3f);
		cy(2);
		chk(lbt, 'h3f);
		wr(smlc_pkg::ADDR_LOW_BATTERY_CONFIG, 'h2a);
		rc(smlc_pkg::ADDR_LOW_BATTERY_CONFIG, 'h40, 0);
		cy(25);
		rc(smlc_pkg::ADDR_LOW_BATTERY_CONFIG, 'hff, 'h6a);
		@(posedge clk) sup <= 12'h8fc;
		cy(6);
		rc(smlc_pkg::ADDR_LOW_BATTERY_CONFIG, 'hc0, 'hc0);
		wr(smlc_pkg::ADDR_IRQ_ENABLE, 2);
		cy(2);
		chk(irq, 1);
		wr(smlc_pkg::ADDR_IRQ_ENABLE, 0);
		cy(2);
		chk(irq, 0);
		wr(smlc_pkg::ADDR_IRQ_CLEAR, 2);
		wr(smlc_pkg::ADDR_IRQ_ENABLE, 2);
		cy(2);
		chk(irq, 0);
		rc(smlc_pkg::ADDR_IRQ_STATUS, 2, 0);
		wr(smlc_pkg::ADDR_IRQ_ENABLE, 0);
		endt("low battery");
		wr(smlc_pkg::ADDR_LOCK_CTRL, 'h00420207);
		rc(smlc_pkg::ADDR_LOCK_CTRL, 'hffffff, 'h420207);
		cy(150);
		rc(smlc_pkg::ADDR_LOCK_STATUS, 1, 1);
		@(posedge clk) slip_en <= 1'b1;
		cy(100);
		rc(smlc_pkg::ADDR_LOCK_STATUS, 1, 0);
		@(posedge clk) slip_en <= 1'b0;
		cy(150);
		rc(smlc_pkg::ADDR_LOCK_STATUS, 'h1f, 1);
		endt("lock");
		wr(smlc_pkg::ADDR_VCO_TUNE, 'h1f);
		cy(2);
		chk(cap, 'h1f);
		@(posedge clk) win <= 2'b10;
		cy(5);
		rc(smlc_pkg::ADDR_VCO_TUNE, 'h31f, 'h11f);
		@(posedge clk) win <= 2'b01;
		cy(5);
		rc(smlc_pkg::ADDR_VCO_TUNE, 'h31f, 'h21f);
		endt("vco");
		wr(smlc_pkg::ADDR_TX_CTRL, 'h130);
		cy(2);
		chk(att, 'h24);
		@(posedge clk) tx <= 1'b1;
		cy(1);
		chk(pae, 1);
		@(posedge clk) tx <= 1'b0;
		cy(1);
		chk(pae, 0);
		wr(smlc_pkg::ADDR_TX_CTRL, 'h105);
		cy(2);
		chk(att, 'h05);
		@(posedge clk) tx <= 1'b1;
		endt("transmit");
		@(posedge clk) sup <= 12'h6a4;
		cy(10);
		chk(crb, 0);
		chk(pae, 0);
		@(posedge clk) sup <= 12'h7d0;
		cy(10);
		chk(crb, 1);
		rc(smlc_pkg::ADDR_RESET_STATUS, 5, 4);
		chk(lbt, 'h2a);
		chk(pae, 1);
		rc(smlc_pkg::ADDR_IRQ_STATUS, 1, 1);
		wr(smlc_pkg::ADDR_RESET_STATUS, 7);
		endt("warm reboot");
		@(posedge clk) sup <= 12'h032;
		cy(10);
		chk(crb, 0);
		@(posedge clk) sup <= 12'hce4;
		cy(10);
		chk(crb, 1);
		rc(smlc_pkg::ADDR_RESET_STATUS, 5, 0);
		chk(lbt, 0);
		chk(pae, 0);
		chk(att, 0);
		chk(cap, 'h10);
		endt("cold start");
		report_and_stop;
	end
endmodule
